// [verilog/rtmc_top.sv]
// Purpose: Trigger, remote/local and clear control of an instrument remote interface.
// Assumes: Bus pulse fields and keys arrive as one-cycle pulses synchronous to core_clk; remoteEnable and the address fields are levels.
// Notes: Measurement engine is driven by the measStart strobe and answers with done.
//
// Added by the designer: the placing of the registers and the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none
module rtmc_top #(
  parameter int SETTLE_CYC = rtmc_pkg::RTMC_SETTLE_CYC
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire rtmc_pkg::rtmc_bus_t busMsg,
  input wire rtmc_pkg::rtmc_keys_t keys,
  input wire logic measDone,
  input wire logic srqCondition,
  output logic measStart,
  output logic outputEnable,
  output logic displayBlank,
  output logic timeoutEnable,
  output logic panelKeyAccept,
  output logic remoteLamp,
  output logic listenLamp,
  output logic talkLamp,
  output logic srqLine
);
  typedef enum logic [1:0] {MS_IDLE, MS_SETTLE, MS_MEASURE} rtmc_meas_t;

  rtmc_pkg::rtmc_mode_t mode_q;
  rtmc_meas_t meas_q;
  logic holdMode_q, lockout_q, remEnArmed_q, manualTuneArmed_q;
  logic [31:0] settleCnt_q;
  logic [5:0] srqMask_q, status_q;
  logic [7:0] settings_q;
  logic [31:0] limLo_q, limHi_q, tune_q;
  logic [15:0] entryLen_q;
  logic [31:0] evWrite;
  logic wbHit, clearMsg, trigImm, trigSettled, keyTrig, anyTrig, toLocal, toRemote, holdAllowed;

  // Classic Wishbone: ack one cycle after the strobe, dropped the next cycle.
  assign wbHit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign evWrite = (wbHit && wb_we_i && wb_adr_i == rtmc_pkg::RTMC_EVENT_OFS && wb_sel_i[0]) ? wb_dat_i : 32'h0;

  assign clearMsg = busMsg.deviceClear || evWrite[rtmc_pkg::EV_PRESET];
  // A bus trigger counts only in remote while addressed to listen.
  assign trigImm = evWrite[rtmc_pkg::EV_IMMEDIATE];
  assign trigSettled = evWrite[rtmc_pkg::EV_SETTLED] || (busMsg.busTrigger && mode_q == rtmc_pkg::RTMC_REMOTE
                       && busMsg.listenAddr);
  // The clear key triggers only in held mode and never under lockout.
  assign keyTrig = keys.clearKey && holdMode_q && !lockout_q;
  assign anyTrig = trigImm || trigSettled || keyTrig;
  assign toRemote = mode_q == rtmc_pkg::RTMC_LOCAL && busMsg.remoteEnable && busMsg.listenAddr;
  assign toLocal = mode_q == rtmc_pkg::RTMC_REMOTE && (busMsg.goToLocal || !busMsg.remoteEnable
                   || (keys.localKey && !lockout_q));
  // Hold can only be taken in remote when no clear, local or free-run request competes in the same cycle.
  assign holdAllowed = mode_q == rtmc_pkg::RTMC_REMOTE && !clearMsg && !toLocal && !evWrite[rtmc_pkg::EV_FREE_RUN];

  always_ff @(posedge core_clk) begin
    if (reset) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wbHit;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      wb_dat_o <= 32'h0;
    end else if (wbHit && !wb_we_i) begin
      case (wb_adr_i)
        rtmc_pkg::RTMC_CTRL_OFS: wb_dat_o <= {28'h0, lockout_q, remEnArmed_q, holdMode_q,
                                              mode_q == rtmc_pkg::RTMC_REMOTE};
        rtmc_pkg::RTMC_STATUS_OFS: wb_dat_o <= {24'h0, 1'b0, |status_q, status_q};
        rtmc_pkg::RTMC_SRQMASK_OFS: wb_dat_o <= {26'h0, srqMask_q};
        rtmc_pkg::RTMC_SETTINGS_OFS: wb_dat_o <= {24'h0, settings_q};
        rtmc_pkg::RTMC_LIMLO_OFS: wb_dat_o <= limLo_q;
        rtmc_pkg::RTMC_LIMHI_OFS: wb_dat_o <= limHi_q;
        rtmc_pkg::RTMC_TUNE_OFS: wb_dat_o <= tune_q;
        default: wb_dat_o <= 32'h0;
      endcase
    end
  end

  // Remote/local state; reset stands for power cycling.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      mode_q <= rtmc_pkg::RTMC_LOCAL;
      lockout_q <= 1'b0;
      remEnArmed_q <= 1'b0;
    end else begin
      remEnArmed_q <= busMsg.remoteEnable;
      if (!busMsg.remoteEnable) begin
        lockout_q <= 1'b0;
      end else if (busMsg.localLockout) begin
        lockout_q <= 1'b1;
      end
      if (toLocal) begin
        mode_q <= rtmc_pkg::RTMC_LOCAL;
      end else if (toRemote) begin
        mode_q <= rtmc_pkg::RTMC_REMOTE;
      end
    end
  end

  // Trigger mode. Local and clear force free-run; a code trigger re-arms hold.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      holdMode_q <= 1'b0;
    end else if (clearMsg || toLocal || toRemote || mode_q == rtmc_pkg::RTMC_LOCAL) begin
      holdMode_q <= 1'b0;
    end else if (evWrite[rtmc_pkg::EV_FREE_RUN]) begin
      holdMode_q <= 1'b0;
    end else if (evWrite[rtmc_pkg::EV_HOLD] || trigImm || trigSettled) begin
      holdMode_q <= 1'b1;
    end
  end

  // Measurement sequencer; settled triggers wait out the settling time first.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      meas_q <= MS_IDLE;
      settleCnt_q <= 32'h0;
      measStart <= 1'b0;
    end else begin
      measStart <= 1'b0;
      case (meas_q)
        MS_IDLE: begin
          if (trigImm) begin
            meas_q <= MS_MEASURE;
            measStart <= 1'b1;
          end else if (trigSettled || keyTrig) begin
            meas_q <= MS_SETTLE;
            settleCnt_q <= 32'(SETTLE_CYC - 1);
          end else if (!holdMode_q && mode_q == rtmc_pkg::RTMC_LOCAL) begin
            meas_q <= MS_MEASURE;
            measStart <= 1'b1;
          end
        end
        MS_SETTLE: begin
          if (settleCnt_q == 32'h0) begin
            meas_q <= MS_MEASURE;
            measStart <= 1'b1;
          end else begin
            settleCnt_q <= settleCnt_q - 32'h1;
          end
        end
        MS_MEASURE: begin
          if (measDone) begin
            meas_q <= MS_IDLE;
          end
        end
        default: meas_q <= MS_IDLE;
      endcase
    end
  end

  // Output gating: held mode releases results only after a triggered cycle.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      outputEnable <= 1'b1;
      displayBlank <= 1'b0;
    end else begin
      // Withholding starts in the cycle hold is taken, so no stale result slips out behind it.
      if (anyTrig && holdAllowed) begin
        outputEnable <= 1'b0;
      end else if (evWrite[rtmc_pkg::EV_HOLD] && holdAllowed) begin
        outputEnable <= 1'b0;
      end else if (!holdMode_q) begin
        outputEnable <= 1'b1;
      end else if (meas_q == MS_MEASURE && measDone) begin
        outputEnable <= 1'b1;
      end
      // Free-run: the key blanks the display and touches nothing else.
      displayBlank <= keys.clearKey && !holdMode_q && !lockout_q;
    end
  end

  // Lamps and panel gating.
  always_ff @(posedge core_clk) begin
    if (reset) begin
      remoteLamp <= 1'b0;
      listenLamp <= 1'b0;
      talkLamp <= 1'b0;
      timeoutEnable <= 1'b1;
      panelKeyAccept <= 1'b1;
    end else begin
      remoteLamp <= mode_q == rtmc_pkg::RTMC_REMOTE && !toLocal;
      listenLamp <= busMsg.listenAddr;
      talkLamp <= busMsg.talkAddr;
      timeoutEnable <= mode_q == rtmc_pkg::RTMC_LOCAL;
      panelKeyAccept <= mode_q == rtmc_pkg::RTMC_LOCAL;
    end
  end

  // Service request mask and status. Conditions set over clear.
  always_ff @(posedge core_clk) begin
    if (reset || clearMsg) begin
      srqMask_q <= rtmc_pkg::RTMC_MASK_CODE_ERR;
    end else if (wbHit && wb_we_i && wb_adr_i == rtmc_pkg::RTMC_SRQMASK_OFS && wb_sel_i[0]) begin
      srqMask_q <= wb_dat_i[5:0] | rtmc_pkg::RTMC_MASK_CODE_ERR;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      status_q <= rtmc_pkg::RTMC_STATUS_RESET;
      srqLine <= 1'b0;
    end else begin
      // Going local leaves the pending request alone.
      if (srqCondition) begin
        status_q <= status_q | rtmc_pkg::RTMC_MASK_CODE_ERR;
      end else if (clearMsg || evWrite[rtmc_pkg::EV_STATUS_READ]) begin
        status_q <= rtmc_pkg::RTMC_STATUS_RESET;
      end
      srqLine <= |(status_q & srqMask_q) && !clearMsg;
    end
  end

  // Instrument settings, partial entry and manual-tune default.
  always_ff @(posedge core_clk) begin
    if (reset || clearMsg) begin
      settings_q <= rtmc_pkg::RTMC_SETTINGS_PRESET;
      limLo_q <= rtmc_pkg::RTMC_LIMLO_KHZ;
      limHi_q <= rtmc_pkg::RTMC_LIMHI_KHZ;
      entryLen_q <= 16'h0;
      manualTuneArmed_q <= 1'b1;
      tune_q <= 32'h0;
    end else begin
      if (evWrite[rtmc_pkg::EV_ENTRY_CHAR]) begin
        entryLen_q <= entryLen_q + 16'h1;
        manualTuneArmed_q <= 1'b0;
      end
      if (evWrite[rtmc_pkg::EV_MANUAL_TUNE]) begin
        manualTuneArmed_q <= 1'b0;
        if (manualTuneArmed_q) begin
          tune_q <= rtmc_pkg::RTMC_TUNE_DEFAULT_KHZ;
        end
      end
      if (wbHit && wb_we_i && wb_sel_i[0]) begin
        case (wb_adr_i)
          rtmc_pkg::RTMC_SETTINGS_OFS: settings_q <= wb_dat_i[7:0];
          rtmc_pkg::RTMC_LIMLO_OFS: limLo_q <= wb_dat_i;
          rtmc_pkg::RTMC_LIMHI_OFS: limHi_q <= wb_dat_i;
          rtmc_pkg::RTMC_TUNE_OFS: tune_q <= wb_dat_i;
          default: entryLen_q <= entryLen_q;
        endcase
      end
    end
  end

  property p_imm_start;
    @(posedge core_clk) disable iff (reset)
      (trigImm && meas_q == MS_IDLE) |=> measStart;
  endproperty
  a_imm_no_settle: assert property (p_imm_start) else $error("immediate trigger did not start at once");

  // A settled cycle is two steps: the trigger opens the wait, the expired counter starts the measurement.
  sequence s_settled_trig;
    (trigSettled || keyTrig) && meas_q == MS_IDLE;
  endsequence
  sequence s_settle_done;
    meas_q == MS_SETTLE && settleCnt_q == 32'h0;
  endsequence

  property p_settled_delay;
    @(posedge core_clk) disable iff (reset) s_settled_trig |=> !measStart;
  endproperty
  a_settled_delay: assert property (p_settled_delay) else $error("settled trigger skipped settling");
  property p_settle_start;
    @(posedge core_clk) disable iff (reset) s_settle_done |=> measStart;
  endproperty
  a_settle_start: assert property (p_settle_start) else $error("settling end did not start measurement");

  property p_hold_after_trig;
    @(posedge core_clk) disable iff (reset)
      (trigImm && !clearMsg && mode_q == rtmc_pkg::RTMC_REMOTE && !toLocal) |=> holdMode_q;
  endproperty
  a_hold_after_trig: assert property (p_hold_after_trig) else $error("trigger did not enter hold");

  property p_get_refused;
    @(posedge core_clk) disable iff (reset)
      (busMsg.busTrigger && mode_q == rtmc_pkg::RTMC_REMOTE && !busMsg.listenAddr && !trigImm
       && !evWrite[rtmc_pkg::EV_SETTLED] && !keyTrig && meas_q == MS_IDLE) |=> meas_q == MS_IDLE;
  endproperty
  a_get_refused: assert property (p_get_refused) else $error("bus trigger taken while not listening");

  property p_key_no_hold;
    @(posedge core_clk) disable iff (reset)
      (keys.clearKey && !holdMode_q && !trigImm && !trigSettled && !evWrite[rtmc_pkg::EV_HOLD]) |=> !holdMode_q;
  endproperty
  a_key_no_hold: assert property (p_key_no_hold) else $error("clear key entered hold");

  property p_free_blank;
    @(posedge core_clk) disable iff (reset) (keys.clearKey && !holdMode_q && !lockout_q) |=> displayBlank;
  endproperty
  a_free_blank: assert property (p_free_blank) else $error("clear key did not blank in free-run");

  property p_key_no_clear;
    @(posedge core_clk) disable iff (reset)
      (keys.clearKey && !clearMsg && !evWrite[rtmc_pkg::EV_STATUS_READ] && |status_q) |=> |status_q;
  endproperty
  a_key_no_clear: assert property (p_key_no_clear) else $error("clear key cleared status");

  property p_clear_mask;
    @(posedge core_clk) disable iff (reset)
      clearMsg |=> srqMask_q == rtmc_pkg::RTMC_MASK_CODE_ERR && limLo_q == rtmc_pkg::RTMC_LIMLO_KHZ;
  endproperty
  a_clear_mask: assert property (p_clear_mask) else $error("clear did not preset");
  property p_srq_clear;
    @(posedge core_clk) disable iff (reset) clearMsg |=> !srqLine;
  endproperty
  a_srq_clear: assert property (p_srq_clear) else $error("clear left service request");

  property p_clear_entry;
    @(posedge core_clk) disable iff (reset)
      clearMsg |=> entryLen_q == 16'h0 && settings_q == rtmc_pkg::RTMC_SETTINGS_PRESET;
  endproperty
  a_clear_entry: assert property (p_clear_entry) else $error("clear kept partial entry");

  property p_tune_default;
    @(posedge core_clk) disable iff (reset)
      (evWrite[rtmc_pkg::EV_MANUAL_TUNE] && manualTuneArmed_q && !clearMsg)
      |=> tune_q == rtmc_pkg::RTMC_TUNE_DEFAULT_KHZ;
  endproperty
  a_tune_default: assert property (p_tune_default) else $error("manual tune missed default");

  property p_panel_remote;
    @(posedge core_clk) disable iff (reset) mode_q == rtmc_pkg::RTMC_REMOTE |=> !panelKeyAccept;
  endproperty
  a_panel_remote: assert property (p_panel_remote) else $error("panel keys accepted in remote");
  property p_timeout_remote;
    @(posedge core_clk) disable iff (reset) mode_q == rtmc_pkg::RTMC_REMOTE |=> !timeoutEnable;
  endproperty
  a_timeout_remote: assert property (p_timeout_remote) else $error("display timeout ran in remote");

  property p_remote_lamp;
    @(posedge core_clk) disable iff (reset) mode_q == rtmc_pkg::RTMC_LOCAL |=> !remoteLamp;
  endproperty
  a_remote_lamp: assert property (p_remote_lamp) else $error("remote lamp lit in local");
  property p_listen_lamp;
    @(posedge core_clk) disable iff (reset) 1'b1 |=> listenLamp == $past(busMsg.listenAddr);
  endproperty
  a_listen_lamp: assert property (p_listen_lamp) else $error("listen lamp does not follow address");

  property p_local_free_run;
    @(posedge core_clk) disable iff (reset) mode_q == rtmc_pkg::RTMC_LOCAL |=> !holdMode_q;
  endproperty
  a_local_free_run: assert property (p_local_free_run) else $error("hold while local");

  property p_remote_entry;
    @(posedge core_clk) disable iff (reset) toRemote |=> mode_q == rtmc_pkg::RTMC_REMOTE && !holdMode_q;
  endproperty
  a_remote_entry: assert property (p_remote_entry) else $error("remote entry not in free-run");

  property p_key_local;
    @(posedge core_clk) disable iff (reset)
      (keys.localKey && !lockout_q && mode_q == rtmc_pkg::RTMC_REMOTE) |=> mode_q == rtmc_pkg::RTMC_LOCAL;
  endproperty
  a_key_local: assert property (p_key_local) else $error("local key did not return to local");

  property p_srq_keep;
    @(posedge core_clk) disable iff (reset)
      (toLocal && |(status_q & srqMask_q) && !clearMsg) |=> srqLine;
  endproperty
  a_srq_keep: assert property (p_srq_keep) else $error("going local dropped service request");

  property p_lockout_keys;
    @(posedge core_clk) disable iff (reset)
      (lockout_q && busMsg.remoteEnable && !busMsg.goToLocal && mode_q == rtmc_pkg::RTMC_REMOTE)
      |=> mode_q == rtmc_pkg::RTMC_REMOTE;
  endproperty
  a_lockout_keys: assert property (p_lockout_keys) else $error("local key acted under lockout");
  property p_lockout_blank;
    @(posedge core_clk) disable iff (reset) lockout_q |=> !displayBlank;
  endproperty
  a_lockout_blank: assert property (p_lockout_blank) else $error("clear key acted under lockout");

  property p_hold_withhold;
    @(posedge core_clk) disable iff (reset) (anyTrig && holdAllowed) |=> !outputEnable;
  endproperty
  a_hold_withhold: assert property (p_hold_withhold) else $error("output not withheld on trigger");
  property p_output_release;
    @(posedge core_clk) disable iff (reset)
      (holdMode_q && meas_q == MS_MEASURE && measDone && !anyTrig && !evWrite[rtmc_pkg::EV_HOLD]) |=> outputEnable;
  endproperty
  a_output_release: assert property (p_output_release) else $error("result not released after trigger");
endmodule
`default_nettype wire

// [verilog/rtmc_pkg.sv]
// Purpose: Constants and types for the remote trigger and mode control block.
// Assumes: One 25 MHz clock, synchronous active-high reset, classic Wishbone slave.
// Notes: Register offsets are byte addresses of 32-bit words.
package rtmc_pkg;
  localparam logic [7:0] RTMC_CTRL_OFS = 8'h00;
  localparam logic [7:0] RTMC_EVENT_OFS = 8'h04;
  localparam logic [7:0] RTMC_STATUS_OFS = 8'h08;
  localparam logic [7:0] RTMC_SRQMASK_OFS = 8'h0c;
  localparam logic [7:0] RTMC_SETTINGS_OFS = 8'h10;
  localparam logic [7:0] RTMC_LIMLO_OFS = 8'h14;
  localparam logic [7:0] RTMC_LIMHI_OFS = 8'h18;
  localparam logic [7:0] RTMC_TUNE_OFS = 8'h1c;
  // Event register bit positions (write 1 to strobe).
  localparam int EV_FREE_RUN = 0;
  localparam int EV_HOLD = 1;
  localparam int EV_IMMEDIATE = 2;
  localparam int EV_SETTLED = 3;
  localparam int EV_PRESET = 4;
  localparam int EV_MANUAL_TUNE = 5;
  localparam int EV_ENTRY_CHAR = 6;
  localparam int EV_STATUS_READ = 7;
  localparam logic [5:0] RTMC_MASK_CODE_ERR = 6'h02;
  localparam logic [5:0] RTMC_STATUS_RESET = 6'h00;
  localparam logic [31:0] RTMC_LIMLO_KHZ = 32'd150;
  localparam logic [31:0] RTMC_LIMHI_KHZ = 32'd1300000;
  localparam logic [31:0] RTMC_TUNE_DEFAULT_KHZ = 32'd100000;
  localparam logic [7:0] RTMC_SETTINGS_PRESET = 8'h00;
  localparam int RTMC_CLK_MHZ = 25;
  localparam int RTMC_SETTLE_US = 20;
  localparam int RTMC_SETTLE_CYC = RTMC_SETTLE_US * RTMC_CLK_MHZ;
  localparam int RTMC_MEAS_CYC = 8;
  typedef enum logic [1:0] {RTMC_LOCAL, RTMC_REMOTE} rtmc_mode_t;
  typedef struct packed {
    logic remoteEnable;
    logic listenAddr;
    logic talkAddr;
    logic goToLocal;
    logic localLockout;
    logic deviceClear;
    logic busTrigger;
  } rtmc_bus_t;
  typedef struct packed {
    logic localKey;
    logic clearKey;
    logic otherKey;
  } rtmc_keys_t;
endpackage

// [verif/rtmc_ctl_model.sv]
// Purpose: Bus controller and measurement engine stand-in for the trigger control block.
// Assumes: Messages change just after a rising core_clk edge.
// Notes: Levels persist between sends; pulse fields last exactly one cycle.
`timescale 1ns/10ps
`default_nettype none
module rtmc_ctl_model #(
  parameter int MEAS_LAT = 6
) (
  input wire logic core_clk,
  input wire logic measStart,
  output var rtmc_pkg::rtmc_bus_t busMsg,
  output var logic measDone
);
  int cnt;
  initial begin
    busMsg = '0;
    measDone = 1'b0;
    cnt = 0;
  end
  always @(posedge core_clk) begin
    measDone <= (cnt == 1);
    if (measStart === 1'b1) begin
      cnt <= MEAS_LAT;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
  task automatic send(input logic [6:0] m);
    @(posedge core_clk);
    busMsg <= m;
    @(posedge core_clk);
    busMsg <= {m[6:4], 4'h0};
  endtask
endmodule
`default_nettype wire

// [verif/test_remote_trigger_mode_control.sv]
// Purpose: Self-checking bench for the trigger and remote/local control block.
// Assumes: Wishbone classic single cycles; settling shortened to SET cycles.
// Notes: Code triggers are issued from held mode so free-run activity cannot pollute counts.
`timescale 1ns/10ps
`default_nettype none
module test_remote_trigger_mode_control;
  localparam int SET = 4;
  logic core_clk, reset, cyc, stb, we, ack, mDone, mStart, oe, blank, toEn, pka, rl, ll, tl, srq, srqC;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dw, dr, v;
  logic [6:0] lv;
  rtmc_pkg::rtmc_keys_t keys;
  rtmc_pkg::rtmc_bus_t bm;
  int mismatches, checks, starts, blanks, cycN, lastStart, dI, dS, s;
  rtmc_top #(.SETTLE_CYC(SET)) u_dut(.core_clk(core_clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack),
    .busMsg(bm), .keys(keys), .measDone(mDone), .srqCondition(srqC), .measStart(mStart),
    .outputEnable(oe), .displayBlank(blank), .timeoutEnable(toEn), .panelKeyAccept(pka),
    .remoteLamp(rl), .listenLamp(ll), .talkLamp(tl), .srqLine(srq));
  rtmc_ctl_model u_ctl(.core_clk(core_clk), .measStart(mStart), .busMsg(bm), .measDone(mDone));
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycN <= cycN + 1;
    if (mStart === 1'b1) begin
      starts <= starts + 1;
      lastStart <= cycN;
    end
    if (blank === 1'b1) begin
      blanks <= blanks + 1;
    end
  end
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // Request held until the edge where ack is sampled; read data taken there.
  task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    adr <= a;
    dw <= d;
    sel <= 4'hf;
    for (i = 0; i < 50; i++) begin
      @(posedge core_clk);
      if (ack === 1'b1) break;
    end
    v = dr;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    chk("wb_ack_o", 32'(i < 50), 32'h1);
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string n);
    acc(1'b0, a, 32'h0);
    chk(n, v, e);
  endtask
  task automatic ev(input int b);
    acc(1'b1, rtmc_pkg::RTMC_EVENT_OFS, 32'h1 << b);
  endtask
  task automatic key(input logic [2:0] k);
    @(posedge core_clk);
    keys <= k;
    @(posedge core_clk);
    keys <= '0;
    w(3);
  endtask
  task automatic bus(input logic [6:0] m);
    u_ctl.send(m);
    w(3);
  endtask
  task automatic sc;
    @(posedge core_clk);
    srqC <= 1'b1;
    @(posedge core_clk);
    srqC <= 1'b0;
    w(3);
  endtask
  task automatic trg(input int b, output int d);
    int t;
    ev(rtmc_pkg::EV_HOLD);
    s = starts;
    t = cycN;
    ev(b);
    w(SET + 12);
    chk("starts", starts - s, 32'h1);
    d = lastStart - t;
  endtask
  initial begin
    {cyc, stb, we, adr, sel, dw, srqC} = '0;
    keys = '0;
    {mismatches, checks, starts, blanks, cycN, lastStart} = '0;
    reset = 1'b1;
    w(20);
    reset <= 1'b0;
    rc(rtmc_pkg::RTMC_CTRL_OFS, 32'h0, "ctrl");
    chk("timeoutEnable", toEn, 32'h1);
    ev(rtmc_pkg::EV_HOLD);
    rc(rtmc_pkg::RTMC_CTRL_OFS, 32'h0, "ctrl");
    $display("test local done");
    lv = 7'h40;
    bus(lv);
    rc(rtmc_pkg::RTMC_CTRL_OFS, 32'h4, "ctrl");
    lv = 7'h70;
    bus(lv);
    rc(rtmc_pkg::RTMC_CTRL_OFS, 32'h5, "ctrl");
    chk("remoteLamp", rl, 32'h1);
    chk("talkLamp", tl, 32'h1);
    chk("listenLamp", ll, 32'h1);
    chk("timeoutEnable", toEn, 32'h0);
    chk("panelKeyAccept", pka, 32'h0);
    ev(rtmc_pkg::EV_HOLD);
    chk("outputEnable", oe, 32'h0);
    trg(rtmc_pkg::EV_IMMEDIATE, dI);
    rc(rtmc_pkg::RTMC_CTRL_OFS, 32'h7, "ctrl");
    chk("outputEnable", oe, 32'h1);
    trg(rtmc_pkg::EV_SETTLED, dS);
    chk("settle", dS - dI, SET);
    rc(rtmc_pkg::RTMC_CTRL_OFS, 32'h7, "ctrl");
    ev(rtmc_pkg::EV_FREE_RUN);
    s = starts;
    bus(lv | 7'h01);
    w(SET + 12);
    chk("starts", starts - s, 32'h1);
    rc(rtmc_pkg::RTMC_CTRL_OFS, 32'h7, "ctrl");
    s = starts;
    key(3'b010);
    w(SET + 12);
    chk("starts", starts - s, 32'h1);
    rc(rtmc_pkg::RTMC_CTRL_OFS, 32'h7, "ctrl");
    bus(7'h50);
    s = starts;
    bus(7'h51);
    w(SET + 12);
    chk("starts", starts - s, 32'h0);
    bus(lv);
    $display("test triggers done");
    acc(1'b1, rtmc_pkg::RTMC_SRQMASK_OFS, 32'h3d);
    ev(rtmc_pkg::EV_FREE_RUN);
    s = blanks;
    key(3'b010);
    chk("blanks", blanks - s, 32'h1);
    rc(rtmc_pkg::RTMC_CTRL_OFS, 32'h5, "ctrl");
    rc(rtmc_pkg::RTMC_SRQMASK_OFS, 32'h3f, "mask");
    sc();
    acc(1'b1, rtmc_pkg::RTMC_SETTINGS_OFS, 32'hff);
    ev(rtmc_pkg::EV_ENTRY_CHAR);
    ev(rtmc_pkg::EV_HOLD);
    bus(lv | 7'h02);
    rc(rtmc_pkg::RTMC_SRQMASK_OFS, 32'h2, "mask");
    rc(rtmc_pkg::RTMC_STATUS_OFS, 32'h0, "status");
    chk("srqLine", srq, 32'h0);
    acc(1'b0, rtmc_pkg::RTMC_SETTINGS_OFS, 32'h0);
    chk("settings", v[7:0], 32'h0);
    rc(rtmc_pkg::RTMC_LIMLO_OFS, 32'd150, "limlo");
    rc(rtmc_pkg::RTMC_LIMHI_OFS, 32'd1300000, "limhi");
    rc(rtmc_pkg::RTMC_CTRL_OFS, 32'h5, "ctrl");
    ev(rtmc_pkg::EV_MANUAL_TUNE);
    rc(rtmc_pkg::RTMC_TUNE_OFS, 32'd100000, "tune");
    $display("test clear done");
    sc();
    lv = 7'h40;
    bus(lv);
    key(3'b100);
    rc(rtmc_pkg::RTMC_CTRL_OFS, 32'h4, "ctrl");
    chk("remoteLamp", rl, 32'h0);
    chk("srqLine", srq, 32'h1);
    lv = 7'h60;
    bus(lv);
    bus(lv | 7'h04);
    ev(rtmc_pkg::EV_HOLD);
    key(3'b100);
    rc(rtmc_pkg::RTMC_CTRL_OFS, 32'hf, "ctrl");
    s = starts;
    key(3'b010);
    w(SET + 12);
    chk("starts", starts - s, 32'h0);
    lv = 7'h40;
    bus(lv);
    bus(lv | 7'h08);
    acc(1'b0, rtmc_pkg::RTMC_CTRL_OFS, 32'h0);
    chk("ctrl", v[1:0], 32'h0);
    bus(7'h00);
    rc(rtmc_pkg::RTMC_CTRL_OFS, 32'h0, "ctrl");
    $display("test local mode done");
    close_out();
  end
  initial begin
    #(40 * 20000);
    mismatches++;
    $display("BAD watchdog expected done seen timeout");
    close_out();
  end
endmodule
`default_nettype wire
